/* File: verilog/hbr_top.sv */
// host port control: reset, bus width, transfer acknowledge, interrupt request
`timescale 1ns/100ps
module hbr_top (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic reset_pin_i,
  input wire logic width_sel_i,
  input wire logic addr_latch_i,
  input wire logic chip_sel_n_i,
  input wire logic rd_data_strobe_n_i,
  input wire logic wr_rw_i,
  input wire logic irq_ack_in_n_i,
  input wire logic addr0_i,
  input wire logic byte_lane_enable_n_i,
  input wire logic chain_enable_in_i,
  input wire logic osc_in_i,
  input wire logic xfer_ready_i,
  input wire logic [hbr_pkg::NCH-1:0] channel_power_up_bit_wr_i,
  input wire logic [hbr_pkg::NCH-1:0] channel_power_up_bit_i,
  input wire logic [hbr_pkg::CH_SRC_W-1:0] chan_irq_evt_i,
  input wire logic [hbr_pkg::CH_SRC_W-1:0] channel_irq_mask_regs_i,
  input wire logic [hbr_pkg::CH_SRC_W-1:0] chan_irq_clr_i,
  input wire logic [hbr_pkg::PT_SRC_W-1:0] port_irq_evt_i,
  input wire logic [hbr_pkg::PT_SRC_W-1:0] port_irq_mask_regs_i,
  input wire logic [hbr_pkg::PT_SRC_W-1:0] port_irq_clr_i,
  input wire logic [hbr_pkg::NPORT-1:0] port_irq_enable_i,
  input wire logic [1:0] irq_port_config_i,
  input wire logic daisy_mode_i,
  output logic dev_reset_o,
  output logic powered_up_o,
  output logic [hbr_pkg::NCH-1:0] chan_power_o,
  output logic osc_enable_o,
  output logic osc_out_o,
  output logic osc_out_oe_o,
  output hbr_pkg::hbr_bus_mode_t bus_mode_o,
  output logic word_mode_o,
  output logic lane_lo_o,
  output logic lane_hi_o,
  output logic data_lo_oe_o,
  output logic data_hi_oe_o,
  output logic reg_rd_o,
  output logic reg_wr_o,
  output logic transfer_ack_out_o,
  output logic transfer_ack_out_oe_o,
  output logic [hbr_pkg::CH_SRC_W-1:0] channel_irq_status_regs_o,
  output logic [hbr_pkg::PT_SRC_W-1:0] port_irq_status_regs_o,
  output logic [hbr_pkg::SUM_W-1:0] global_irq_summary_o,
  output logic irq_o,
  output logic irq_oe_o
);
  import hbr_pkg::*;

  // pin inputs gathered for synchronisation
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s;
  assign pin_raw[PIN_RES] = reset_pin_i;
  assign pin_raw[PIN_WIDTH] = width_sel_i;
  assign pin_raw[PIN_ALE] = addr_latch_i;
  assign pin_raw[PIN_CS_N] = chip_sel_n_i;
  assign pin_raw[PIN_RD_STB_N] = rd_data_strobe_n_i;
  assign pin_raw[PIN_WR_RW] = wr_rw_i;
  assign pin_raw[PIN_ACK_N] = irq_ack_in_n_i;
  assign pin_raw[PIN_A0] = addr0_i;
  assign pin_raw[PIN_LANE_N] = byte_lane_enable_n_i;
  assign pin_raw[PIN_CHAIN] = chain_enable_in_i;
  assign pin_raw[PIN_OSC] = osc_in_i;

  // every pin passes two flops, the reset pin among them
  hbr_sync #(
    .W(PIN_W),
    .RST_VAL(PIN_RST_VAL)
  ) u_pin_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(pin_raw),
    .q_o(pin_s)
  );

  // named views of the synchronised pins
  wire dev_rst = pin_s[PIN_RES];
  wire wide = pin_s[PIN_WIDTH];
  wire ale_s = pin_s[PIN_ALE];
  wire cs_act = !pin_s[PIN_CS_N];
  wire rd_pin_n = pin_s[PIN_RD_STB_N];
  wire rw_pin = pin_s[PIN_WR_RW];
  wire ack_in_act = !pin_s[PIN_ACK_N];
  wire a0_s = pin_s[PIN_A0];
  wire lane_en_act = !pin_s[PIN_LANE_N];
  wire chain_s = pin_s[PIN_CHAIN];
  wire osc_s = pin_s[PIN_OSC];

  // bus mode from the latch strobe level, toggling latches muxed mode
  logic ale_prev_q;
  logic ale_tog_q;
  wire ale_edge = ale_s != ale_prev_q;
  hbr_bus_mode_t mode_d;
  assign mode_d = (ale_tog_q || ale_edge) ? MODE_SEP_MUX :
                  (ale_s ? MODE_ONE_DEMUX : MODE_SEP_DEMUX);
  wire one_strobe = mode_d == MODE_ONE_DEMUX;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ale_prev_q <= 1'b0;
      ale_tog_q <= 1'b0;
    end else begin
      ale_prev_q <= ale_s;
      ale_tog_q <= dev_rst ? 1'b0 : (ale_tog_q | ale_edge);
    end
  end

  // strobe decode for the two strobe conventions
  wire rd_act = one_strobe ? (!rd_pin_n && rw_pin) : !rd_pin_n;
  wire wr_act = one_strobe ? (!rd_pin_n && !rw_pin) : !rw_pin;
  wire access = cs_act && (rd_act || wr_act);
  wire cyc_act = access || ack_in_act;

  // byte lanes: lane enable means upper byte or lower byte by convention
  wire lane_hi_16 = one_strobe ? !a0_s : lane_en_act;
  wire lane_lo_16 = one_strobe ? lane_en_act : !a0_s;
  wire lane_lo_d = wide ? lane_lo_16 : 1'b1;
  wire lane_hi_d = wide && lane_hi_16;

  // data drivers follow reads and the low driver follows ack cycles, also while in reset
  wire rd_cyc = cs_act && rd_act;
  wire data_lo_oe_d = (rd_cyc && lane_lo_d) || ack_in_act;
  wire data_hi_oe_d = rd_cyc && lane_hi_d && !ack_in_act;

  // registered bus view
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_mode_o <= MODE_SEP_DEMUX;
      word_mode_o <= 1'b0;
      lane_lo_o <= 1'b0;
      lane_hi_o <= 1'b0;
      data_lo_oe_o <= 1'b0;
      data_hi_oe_o <= 1'b0;
      reg_rd_o <= 1'b0;
      reg_wr_o <= 1'b0;
    end else begin
      bus_mode_o <= mode_d;
      word_mode_o <= wide;
      lane_lo_o <= lane_lo_d;
      lane_hi_o <= lane_hi_d;
      data_lo_oe_o <= data_lo_oe_d;
      data_hi_oe_o <= data_hi_oe_d;
      reg_rd_o <= rd_cyc && !dev_rst;
      reg_wr_o <= cs_act && wr_act && !dev_rst;
    end
  end

  // transfer acknowledge: ready raises it, end of cycle drops it
  hbr_ack_state_t ack_st_q;
  hbr_ack_state_t ack_st_d;
  always_comb begin
    ack_st_d = ack_st_q;
    unique case (ack_st_q)
      ACK_IDLE: begin
        if (cyc_act && xfer_ready_i) begin
          ack_st_d = ACK_ON;
        end
      end
      ACK_ON: begin
        if (!cyc_act) begin
          ack_st_d = ACK_IDLE;
        end
      end
    endcase
    if (dev_rst) begin
      ack_st_d = ACK_IDLE;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_st_q <= ACK_IDLE;
      transfer_ack_out_oe_o <= 1'b0;
      transfer_ack_out_o <= 1'b0;
    end else begin
      ack_st_q <= ack_st_d;
      transfer_ack_out_oe_o <= ack_st_d == ACK_ON;
      transfer_ack_out_o <= 1'b0; // open drain only ever pulls low
    end
  end

  // power state and channel power-up bits
  logic [NCH-1:0] pu_q;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pu_q <= PU_RST_VAL;
      chan_power_o <= PWR_RST_VAL;
      powered_up_o <= 1'b1;
      dev_reset_o <= 1'b1;
    end else begin
      pu_q <= dev_rst ? PU_RST_VAL :
              ((pu_q & ~channel_power_up_bit_wr_i) |
               (channel_power_up_bit_i & channel_power_up_bit_wr_i));
      chan_power_o <= dev_rst ? PWR_RST_VAL : pu_q;
      powered_up_o <= dev_rst || (|pu_q);
      dev_reset_o <= dev_rst;
    end
  end

  // oscillator gate: off in reset, output floats in reset while input high
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_enable_o <= 1'b0;
      osc_out_o <= 1'b0;
      osc_out_oe_o <= 1'b0;
    end else begin
      osc_enable_o <= !dev_rst;
      osc_out_o <= !osc_s;
      osc_out_oe_o <= !(dev_rst && osc_s);
    end
  end

  // sticky status bits, set wins over clear
  logic [CH_SRC_W-1:0] ch_stat_q;
  logic [PT_SRC_W-1:0] pt_stat_q;
  wire [CH_SRC_W-1:0] ch_stat_d = chan_irq_evt_i | (ch_stat_q & ~chan_irq_clr_i);
  wire [PT_SRC_W-1:0] pt_stat_d = port_irq_evt_i | (pt_stat_q & ~port_irq_clr_i);
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ch_stat_q <= '0;
      pt_stat_q <= '0;
    end else begin
      ch_stat_q <= dev_rst ? '0 : ch_stat_d;
      pt_stat_q <= dev_rst ? '0 : pt_stat_d;
    end
  end
  assign channel_irq_status_regs_o = ch_stat_q;
  assign port_irq_status_regs_o = pt_stat_q;

  // per channel and per port masked pending, gathered into the summary
  logic [SUM_W-1:0] sum_d;
  genvar gi;
  generate
    for (gi = 0; gi < SUM_W; gi++) begin : g_sum
      if (gi < NCH) begin : g_ch
        assign sum_d[gi] = |(ch_stat_q[gi*CH_SLICE_W +: CH_SLICE_W] &
                             ~channel_irq_mask_regs_i[gi*CH_SLICE_W +: CH_SLICE_W]);
      end else begin : g_pt
        assign sum_d[gi] = port_irq_enable_i[gi-NCH] &&
                           |(pt_stat_q[(gi-NCH)*REG_W +: REG_W] &
                             ~port_irq_mask_regs_i[(gi-NCH)*REG_W +: REG_W]);
      end
    end
  endgenerate

  // request: any pending, gated by chain enable in daisy mode
  wire irq_req = (|sum_d) && (!daisy_mode_i || chain_s) && !dev_rst;
  wire cfg_od = irq_port_config_i != IRQ_PP_LOW && irq_port_config_i != IRQ_PP_HIGH;
  wire irq_out_d = (irq_port_config_i == IRQ_PP_HIGH) ? irq_req :
                   ((irq_port_config_i == IRQ_PP_LOW) ? !irq_req : 1'b0);
  wire irq_oe_d = !dev_rst && (cfg_od ? irq_req : 1'b1);
  logic irq_act_q;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      global_irq_summary_o <= '0;
      irq_act_q <= 1'b0;
      irq_o <= 1'b0;
      irq_oe_o <= 1'b0;
    end else begin
      global_irq_summary_o <= sum_d;
      irq_act_q <= irq_req;
      irq_o <= irq_out_d;
      irq_oe_o <= irq_oe_d;
    end
  end

  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // acknowledge checks
  a_ack_start: assert property (
    !dev_rst && ack_st_q == ACK_IDLE && cyc_act && xfer_ready_i
    |=> transfer_ack_out_oe_o && !transfer_ack_out_o)
    else $error("acknowledge did not start on a ready cycle");
  a_ack_hold: assert property (
    transfer_ack_out_oe_o && cyc_act && !dev_rst |=> transfer_ack_out_oe_o)
    else $error("acknowledge dropped while the cycle was still active");
  a_ack_end: assert property (
    transfer_ack_out_oe_o && !cyc_act |=> !transfer_ack_out_oe_o)
    else $error("acknowledge outlived its cycle");

  // reset checks
  a_reset_float: assert property (
    dev_rst ##1 dev_rst |-> !irq_oe_o && !transfer_ack_out_oe_o && !osc_enable_o)
    else $error("one-way driver active during reset");
  a_reset_data: assert property (
    dev_rst && rd_pin_n && !ack_in_act |=> !data_lo_oe_o && !data_hi_oe_o)
    else $error("data bus driven in reset with strobes high");
  a_osc_float: assert property (dev_rst && osc_s |=> !osc_out_oe_o)
    else $error("oscillator output driven in reset with input high");
  a_power_cycle: assert property (
    $fell(dev_rst) && !(|channel_power_up_bit_wr_i)
    |-> chan_power_o == PWR_RST_VAL ##1 chan_power_o == PU_RST_VAL)
    else $error("channel power not on in reset and off after it");

  // lane checks
  a_narrow_lane: assert property (!wide |=> lane_lo_o && !lane_hi_o && !data_hi_oe_o)
    else $error("upper lane used in 8-bit mode");
  a_wide_lane: assert property (
    wide && !one_strobe && !a0_s && !lane_en_act |=> lane_lo_o && !lane_hi_o)
    else $error("wrong byte lane for a low byte access");

  // interrupt checks
  a_daisy_gate: assert property (daisy_mode_i && !chain_s |=> !irq_act_q)
    else $error("request raised with chain enable low");
  a_daisy_out: assert property (
    daisy_mode_i && !chain_s && irq_port_config_i == IRQ_PP_HIGH |=> !irq_o)
    else $error("request pin active with chain enable low");
  a_pp_drive: assert property (!dev_rst && !cfg_od |=> irq_oe_o)
    else $error("push-pull request pin not driven");
  a_irq_idle: assert property (
    sum_d == '0 |=> !irq_act_q && (!irq_oe_o || !$past(cfg_od)))
    else $error("request held with nothing pending");
  a_stat_set: assert property (
    !dev_rst && chan_irq_evt_i[0] && chan_irq_clr_i[0] |=> channel_irq_status_regs_o[0])
    else $error("status event lost against a clear");

  // mode check
  a_mux_mode: assert property (
    !dev_rst && $changed(ale_s) |=> bus_mode_o == MODE_SEP_MUX [*2])
    else $error("latch strobe toggle did not select muxed mode");

  // covers of the main scenarios
  c_ack_cycle: cover property (ack_st_q == ACK_IDLE ##1 ack_st_q == ACK_ON ##1 ack_st_q == ACK_IDLE);
  c_irq_raised: cover property (!irq_act_q ##1 irq_act_q);
  c_daisy_drop: cover property (daisy_mode_i && irq_act_q ##1 !chain_s);
  c_muxed: cover property (bus_mode_o == MODE_SEP_MUX);
  c_word: cover property (lane_lo_o && lane_hi_o && reg_rd_o);
endmodule // hbr_top

/* File: verilog/hbr_pkg.sv */
// shared constants and types for the host bus control block
package hbr_pkg;
  // sizes of the interrupt source groups
  localparam int unsigned NCH = 8;
  localparam int unsigned CH_REGS = 2;
  localparam int unsigned REG_W = 8;
  localparam int unsigned NPORT = 4;
  localparam int unsigned CH_SRC_W = NCH * CH_REGS * REG_W;
  localparam int unsigned CH_SLICE_W = CH_REGS * REG_W;
  localparam int unsigned PT_SRC_W = NPORT * REG_W;
  localparam int unsigned SUM_W = NCH + NPORT;
  // positions of the pin inputs in the synchroniser vector
  localparam int unsigned PIN_RES = 0;
  localparam int unsigned PIN_WIDTH = 1;
  localparam int unsigned PIN_ALE = 2;
  localparam int unsigned PIN_CS_N = 3;
  localparam int unsigned PIN_RD_STB_N = 4;
  localparam int unsigned PIN_WR_RW = 5;
  localparam int unsigned PIN_ACK_N = 6;
  localparam int unsigned PIN_A0 = 7;
  localparam int unsigned PIN_LANE_N = 8;
  localparam int unsigned PIN_CHAIN = 9;
  localparam int unsigned PIN_OSC = 10;
  localparam int unsigned PIN_W = 11;
  // idle levels of the pins, held by the synchroniser in reset
  localparam logic [PIN_W-1:0] PIN_RST_VAL = 11'h179;
  // bus interface modes chosen by the address latch strobe
  typedef enum logic [1:0] {
    MODE_SEP_DEMUX = 2'h0,
    MODE_ONE_DEMUX = 2'h1,
    MODE_SEP_MUX = 2'h3
  } hbr_bus_mode_t;
  // interrupt output driver types
  localparam logic [1:0] IRQ_OPEN_DRAIN = 2'h0;
  localparam logic [1:0] IRQ_PP_LOW = 2'h1;
  localparam logic [1:0] IRQ_PP_HIGH = 2'h2;
  // transfer acknowledge states
  typedef enum logic {
    ACK_IDLE = 1'b0,
    ACK_ON = 1'b1
  } hbr_ack_state_t;
  // values after reset
  localparam logic [NCH-1:0] PU_RST_VAL = 8'h00;
  localparam logic [NCH-1:0] PWR_RST_VAL = 8'hFF;
endpackage

/* File: verilog/hbr_sync.sv */
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
module hbr_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  // first stage feeds only the second stage
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule // hbr_sync

/* File: tb/hbr_host_model.sv */
// host bus master model driving the parallel port pins
`timescale 1ns/100ps
module hbr_host_model (
  input wire logic core_clk_i,
  input wire logic ack_pin_i,
  output logic cs_n_o,
  output logic strobe_n_o,
  output logic wr_rw_o,
  output logic irq_ack_n_o,
  output logic a0_o,
  output logic lane_n_o,
  output logic ale_o
);
  // idle bus: nothing selected, strobes high, latch strobe low
  initial begin
    {cs_n_o, strobe_n_o, wr_rw_o, irq_ack_n_o, a0_o, lane_n_o, ale_o} = 7'h7E;
  end
  // drive one request, then hold it up to 12 cycles until the pulled-up ack pin is seen low
  task automatic start(input logic rd, input logic ia, input logic a0, input logic b,
                       output logic ok);
    @(negedge core_clk_i);
    a0_o = a0;
    lane_n_o = b;
    irq_ack_n_o = ~ia;
    cs_n_o = ia;
    strobe_n_o = ia | (~ale_o & ~rd);
    wr_rw_o = ale_o ? rd : (ia | rd);
    ok = 1'b0;
    for (int n = 0; n < 12 && !ok; n++) begin
      @(posedge core_clk_i);
      ok = (ack_pin_i === 1'b0);
    end
  endtask
  // release the request; address and lane lines flip so stale levels are not reused
  task automatic finish();
    @(negedge core_clk_i);
    {cs_n_o, strobe_n_o, wr_rw_o, irq_ack_n_o} = 4'hF;
    a0_o = ~a0_o;
    lane_n_o = ~lane_n_o;
    repeat (6) @(negedge core_clk_i);
  endtask
  // latch strobe level, held or toggled by the caller
  task automatic set_ale(input logic v);
    @(negedge core_clk_i);
    ale_o = v;
  endtask
endmodule // hbr_host_model

/* File: tb/tb.sv */
// self-checking bench for the host port control block
`timescale 1ns/100ps
module tb;
  import hbr_pkg::*;
  logic core_clk_i, rst_n_i, reset_pin_i, width_sel_i, osc_in_i, xfer_ready_i;
  logic daisy_mode_i, chain_enable_in_i, ok;
  logic cs_n, strb_n, wr_rw, ack_n, a0, lane_n, ale;
  logic [7:0] channel_power_up_bit_wr_i, channel_power_up_bit_i, chan_power_o;
  logic [127:0] chan_irq_evt_i, channel_irq_mask_regs_i, chan_irq_clr_i;
  logic [127:0] channel_irq_status_regs_o;
  logic [31:0] port_irq_evt_i, port_irq_mask_regs_i, port_irq_clr_i, port_irq_status_regs_o;
  logic [3:0] port_irq_enable_i;
  logic [1:0] irq_port_config_i;
  logic [11:0] global_irq_summary_o;
  hbr_bus_mode_t bus_mode_o;
  logic dev_reset_o, powered_up_o, osc_enable_o, osc_out_o, osc_out_oe_o, word_mode_o;
  logic lane_lo_o, lane_hi_o, data_lo_oe_o, data_hi_oe_o, reg_rd_o, reg_wr_o;
  logic transfer_ack_out_o, transfer_ack_out_oe_o, irq_o, irq_oe_o;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  // open-drain ack line with the system pull-up
  wire ack_pin = transfer_ack_out_oe_o ? transfer_ack_out_o : 1'b1;
  hbr_top i_hbr_top (
    .core_clk_i, .rst_n_i, .reset_pin_i, .width_sel_i, .addr_latch_i(ale),
    .chip_sel_n_i(cs_n), .rd_data_strobe_n_i(strb_n), .wr_rw_i(wr_rw),
    .irq_ack_in_n_i(ack_n), .addr0_i(a0), .byte_lane_enable_n_i(lane_n),
    .chain_enable_in_i, .osc_in_i, .xfer_ready_i, .channel_power_up_bit_wr_i,
    .channel_power_up_bit_i, .chan_irq_evt_i, .channel_irq_mask_regs_i, .chan_irq_clr_i,
    .port_irq_evt_i, .port_irq_mask_regs_i, .port_irq_clr_i, .port_irq_enable_i,
    .irq_port_config_i, .daisy_mode_i, .dev_reset_o, .powered_up_o, .chan_power_o,
    .osc_enable_o, .osc_out_o, .osc_out_oe_o, .bus_mode_o, .word_mode_o, .lane_lo_o,
    .lane_hi_o, .data_lo_oe_o, .data_hi_oe_o, .reg_rd_o, .reg_wr_o, .transfer_ack_out_o,
    .transfer_ack_out_oe_o, .channel_irq_status_regs_o, .port_irq_status_regs_o,
    .global_irq_summary_o, .irq_o, .irq_oe_o
  );
  hbr_host_model i_hbr_host_model (
    .core_clk_i, .ack_pin_i(ack_pin), .cs_n_o(cs_n), .strobe_n_o(strb_n), .wr_rw_o(wr_rw),
    .irq_ack_n_o(ack_n), .a0_o(a0), .lane_n_o(lane_n), .ale_o(ale)
  );
  // 125 MHz clock
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  // verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      summarize();
    end
  end
  // compare tasks for single bits and for vectors
  task automatic chk1(input logic got, input logic exp, input string msg);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic chkv(input logic [127:0] got, input logic [127:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  // one acknowledged bus cycle with lane and driver checks
  task automatic bus(input logic rd, input logic ia, input logic a, input logic b,
                     input logic elo, input logic ehi);
    i_hbr_host_model.start(rd, ia, a, b, ok);
    chk1(ok, 1'b1, "ack given");
    @(negedge core_clk_i);
    if (!ia) begin
      chk1(rd ? reg_rd_o : reg_wr_o, 1'b1, "access level");
      chk1(lane_lo_o, elo, "low lane");
      chk1(lane_hi_o, ehi, "high lane");
    end
    chk1(data_lo_oe_o, rd & elo, "low data drive");
    chk1(data_hi_oe_o, rd & ehi, "high data drive");
    tick(5);
    chk1(transfer_ack_out_oe_o, 1'b1, "ack held");
    i_hbr_host_model.finish();
    chk1(transfer_ack_out_oe_o, 1'b0, "ack dropped");
  endtask
  // interrupt pin level for the programmed output type
  task automatic irq_is(input logic act);
    if (irq_port_config_i == IRQ_PP_HIGH) chk1(irq_o, act, "irq high type");
    else if (irq_port_config_i == IRQ_PP_LOW) chk1(irq_o, ~act, "irq low type");
    else chk1(irq_oe_o, act, "irq open drain");
  endtask
  // one-cycle event or clear pulse on a channel or port status bit
  task automatic ev(input int i, input logic pt, input logic clr);
    @(negedge core_clk_i);
    if (pt && clr) port_irq_clr_i[i] = 1'b1;
    else if (pt) port_irq_evt_i[i] = 1'b1;
    else if (clr) chan_irq_clr_i[i] = 1'b1;
    else chan_irq_evt_i[i] = 1'b1;
    @(negedge core_clk_i);
    {chan_irq_evt_i, chan_irq_clr_i, port_irq_evt_i, port_irq_clr_i} = '0;
    tick(3);
  endtask
  // main sequence
  initial begin
    {rst_n_i, reset_pin_i, width_sel_i, osc_in_i, xfer_ready_i, daisy_mode_i} = 6'h16;
    chain_enable_in_i = 1'b0;
    {channel_power_up_bit_wr_i, channel_power_up_bit_i, chan_irq_evt_i} = '0;
    {channel_irq_mask_regs_i, chan_irq_clr_i, port_irq_evt_i, port_irq_mask_regs_i} = '0;
    {port_irq_clr_i, port_irq_enable_i, irq_port_config_i} = '0;
    tick(20);
    chkv(chan_power_o, 8'hFF, "power in reset");
    chk1(osc_enable_o, 1'b0, "osc off");
    chk1(transfer_ack_out_oe_o | irq_oe_o, 1'b0, "drivers float");
    rst_n_i = 1'b1;
    tick(4);
    chk1(dev_reset_o & powered_up_o, 1'b1, "pin reset");
    chk1(osc_out_oe_o, 1'b0, "osc out float");
    chk1(data_lo_oe_o | data_hi_oe_o, 1'b0, "data float");
    osc_in_i = 1'b0;
    tick(4);
    chk1(osc_out_oe_o & osc_out_o, 1'b1, "osc out driven");
    i_hbr_host_model.start(1'b1, 1'b0, 1'b0, 1'b1, ok);
    chk1(ok | reg_rd_o, 1'b0, "no access in reset");
    i_hbr_host_model.finish();
    reset_pin_i = 1'b0;
    tick(5);
    chk1(dev_reset_o | powered_up_o, 1'b0, "reset left");
    chkv(chan_power_o, 8'h00, "power down");
    chk1(osc_enable_o, 1'b1, "osc on");
    {channel_power_up_bit_wr_i, channel_power_up_bit_i} = 16'h0808;
    tick(1);
    channel_power_up_bit_wr_i = 8'h00;
    tick(2);
    chkv(chan_power_o, 8'h08, "channel up");
    $display("test reset done");
    chkv({bus_mode_o, word_mode_o}, 3'h0, "8-bit mode");
    bus(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    bus(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    width_sel_i = 1'b1;
    for (int m = 0; m < 2; m++) begin
      reset_pin_i = 1'b1;
      tick(4);
      i_hbr_host_model.set_ale(m[0]);
      tick(2);
      reset_pin_i = 1'b0;
      tick(5);
      chkv({bus_mode_o, word_mode_o}, m ? 3'h3 : 3'h1, "16-bit mode");
      for (int k = 0; k < 3; k++) begin
        bus(k != 2, 1'b0, k == 1, k == 0, m ? k != 0 : k != 1, m ? k != 1 : k != 0);
      end
    end
    bus(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
    xfer_ready_i = 1'b0;
    i_hbr_host_model.start(1'b1, 1'b0, 1'b0, 1'b0, ok);
    chk1(ok, 1'b0, "no ack unready");
    i_hbr_host_model.finish();
    xfer_ready_i = 1'b1;
    $display("test bus done");
    for (int c = 0; c < 3; c++) begin
      irq_port_config_i = c[1:0];
      ev(c * 17, 1'b0, 1'b0);
      chkv(channel_irq_status_regs_o, 128'h1 << (c * 17), "chan status");
      chkv(global_irq_summary_o, 12'h001 << c, "summary");
      irq_is(1'b1);
      ev(c * 17, 1'b0, 1'b1);
      chkv(global_irq_summary_o, 12'h000, "summary clear");
      irq_is(1'b0);
    end
    channel_irq_mask_regs_i[117] = 1'b1;
    ev(117, 1'b0, 1'b0);
    chk1(channel_irq_status_regs_o[117], 1'b1, "masked status");
    chkv(global_irq_summary_o, 12'h000, "masked summary");
    irq_is(1'b0);
    ev(117, 1'b0, 1'b1);
    ev(17, 1'b1, 1'b0);
    chkv(port_irq_status_regs_o, 32'h0002_0000, "port status");
    chkv(global_irq_summary_o, 12'h000, "port off");
    port_irq_enable_i = 4'h4;
    tick(3);
    chkv(global_irq_summary_o, 12'h400, "port summary");
    irq_is(1'b1);
    port_irq_mask_regs_i[17] = 1'b1;
    tick(3);
    irq_is(1'b0);
    ev(17, 1'b1, 1'b1);
    daisy_mode_i = 1'b1;
    ev(0, 1'b0, 1'b0);
    ev(40, 1'b0, 1'b0);
    irq_is(1'b0);
    chain_enable_in_i = 1'b1;
    tick(4);
    irq_is(1'b1);
    ev(0, 1'b0, 1'b1);
    irq_is(1'b1);
    chain_enable_in_i = 1'b0;
    tick(3);
    irq_is(1'b0);
    {chan_irq_evt_i[0], chan_irq_clr_i[0]} = 2'h3;
    tick(1);
    {chan_irq_evt_i[0], chan_irq_clr_i[0]} = 2'h0;
    tick(1);
    chk1(channel_irq_status_regs_o[0], 1'b1, "set beats clear");
    $display("test irq done");
    for (int t = 0; t < 4; t++) begin
      i_hbr_host_model.set_ale(t[0]);
    end
    tick(4);
    chkv(bus_mode_o, 2'h3, "muxed mode");
    $display("test mode done");
    summarize();
  end
endmodule // tb
